/* File: tpcu_bench.sv */
// Purpose: Self-checking bench for the timer PWM channel update block.
// Assumes: Prescale 0, so one counter tick per bus clock when running, except edge_ps1 at prescale 1.
// Notes: Duty is measured over whole periods, so phase does not matter.
`timescale 1ns/100ps
module tpcu_bench
   import tpcu_pkg::*;
();
   // =========================================================
   // Stimulus signals and score counters
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [5:0] address = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic debug_halt = 1'b0;
   logic [31:0] readdata;
   logic waitrequest;
   logic chan_pin;
   logic chan_pin_oe;
   logic irq;
   int errors = 0;
   int samples_checked = 0;

   tpcu_top dut_u (
      .sys_clk_i(sys_clk), .arst_n_i(arst_n), .avs_address_i(address),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_readdata_o(readdata), .avs_waitrequest_o(waitrequest),
      .debug_halt_i(debug_halt), .chan_pin_o(chan_pin),
      .chan_pin_oe_o(chan_pin_oe), .irq_o(irq));

   // The clock toggles every half period of 5 ns.
   always #5 sys_clk = ~sys_clk;

   // =========================================================
   // Shared tasks
   task automatic end_sim();
      if (errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask

   // One Avalon cycle; the request holds until waitrequest is seen low.
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      bit done;
      done = 0;
      @(posedge sys_clk);
      address <= a;
      wr <= w;
      rd <= ~w;
      wdata <= d;
      for (int n = 0; n < 50 && !done; n++)
      begin
         @(posedge sys_clk);
         if (waitrequest === 1'b0)
            done = 1;
      end
      q = readdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (!done)
      begin
         $display("[FAIL] waitrequest expected 0 seen 1");
         errors++;
         end_sim();
      end
   endtask

   task automatic put(input logic [5:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, {24'h00_0000, d}, q);
   endtask

   task automatic get(input logic [5:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0000_0000, q);
   endtask

   // Counts cycles with the pin high over a window of n cycles.
   task automatic duty(input int n, output int h);
      h = 0;
      repeat (n)
      begin
         @(posedge sys_clk);
         if (chan_pin === 1'b1)
            h++;
      end
   endtask

   // Sets a new channel value and lets it reach the active register.
   task automatic set_val(input logic [7:0] v);
      put(TPCU_OFS_VAL_HI, 8'h00);
      put(TPCU_OFS_VAL_LO, v);
      repeat (32) @(posedge sys_clk);
   endtask

   // =========================================================
   // Scenarios
   task automatic t_freeze();
      logic [31:0] q;
      logic p;
      get(TPCU_OFS_CSC, q);
      chk("csc_reset", 32'h0000_0000, q);
      get(6'h3C, q);
      chk("unmapped", 32'h0000_0000, q);
      put(TPCU_OFS_MOD_HI, 8'h00);
      put(TPCU_OFS_MOD_LO, 8'h07);
      put(TPCU_OFS_VAL_HI, 8'h00);
      put(TPCU_OFS_VAL_LO, 8'h05);
      chk("oe_els_off", 32'h0000_0000, {31'h0, chan_pin_oe});
      put(TPCU_OFS_CSC, 8'h08);
      repeat (2) @(posedge sys_clk);
      chk("oe_els_on", 32'h0000_0001, {31'h0, chan_pin_oe});
      p = chan_pin;
      repeat (20)
      begin
         @(posedge sys_clk);
         chk("pin_frozen", {31'h0, p}, {31'h0, chan_pin});
      end
      get(TPCU_OFS_VAL_LO, q);
      chk("val_no_clock", 32'h0000_0000, q);
   endtask

   task automatic t_edge();
      logic [31:0] q;
      int h;
      q = 32'h0000_0000;
      put(TPCU_OFS_CSC, 8'h00);
      put(TPCU_OFS_TSC, 8'h08);
      for (int n = 0; n < 20 && q[7] !== 1'b1; n++)
         get(TPCU_OFS_TSC, q);
      chk("ovf_before_pin", 32'h0000_0001, {31'h0, q[7]});
      chk("oe_port_ctl", 32'h0000_0000, {31'h0, chan_pin_oe});
      if (q[7] !== 1'b1)
         end_sim();
      put(TPCU_OFS_CSC, 8'h08);
      repeat (24) @(posedge sys_clk);
      get(TPCU_OFS_VAL_LO, q);
      chk("val_loaded", 32'h0000_0005, q);
      duty(16, h);
      chk("edge_duty5", 32'd10, h);
      put(TPCU_OFS_VAL_HI, 8'h01);
      repeat (24) @(posedge sys_clk);
      get(TPCU_OFS_VAL_HI, q);
      chk("half_write", 32'h0000_0000, q);
      put(TPCU_OFS_VAL_LO, 8'h03);
      repeat (24) @(posedge sys_clk);
      get(TPCU_OFS_VAL_HI, q);
      chk("pair_done", 32'h0000_0001, q);
      set_val(8'h03);
      duty(16, h);
      chk("edge_duty3", 32'd6, h);
      put(TPCU_OFS_CSC, 8'h0C);
      repeat (4) @(posedge sys_clk);
      duty(16, h);
      chk("edge_low_true", 32'd10, h);
      put(TPCU_OFS_CSC, 8'h08);
      // Prescale 1 doubles every step, so a period spans 16 clocks.
      put(TPCU_OFS_TSC, 8'h09);
      repeat (40) @(posedge sys_clk);
      duty(32, h);
      chk("edge_ps1", 32'd12, h);
   endtask

   task automatic t_center();
      int h;
      int hold;
      put(TPCU_OFS_TSC, 8'h00);
      put(TPCU_OFS_CNT_LO, 8'h00);
      put(TPCU_OFS_TSC, 8'h28);
      set_val(8'h07);
      duty(28, h);
      chk("ctr_full", 32'd28, h);
      set_val(8'h06);
      duty(28, h);
      chk("ctr_almost", 32'd22, h);
      set_val(8'h00);
      duty(28, h);
      chk("ctr_zero", 32'd0, h);
      put(TPCU_OFS_VAL_HI, 8'h00);
      put(TPCU_OFS_VAL_LO, 8'h03);
      duty(4, hold);
      chk("zero_to_set", 32'd0, hold);
      repeat (28) @(posedge sys_clk);
      duty(28, h);
      chk("ctr_duty3", 32'd10, h);
      set_val(8'h00);
      duty(28, h);
      chk("set_to_zero", 32'd0, h);
   endtask

   // Waits for the interrupt line, counting a mismatch if it never rises.
   // The first edge is skipped so a level from before a clear is not seen.
   task automatic wait_irq();
      int n;
      n = 0;
      @(posedge sys_clk);
      while (irq !== 1'b1 && n < 60)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk("irq_rise", 32'h0000_0001, {31'h0, irq});
      if (irq !== 1'b1)
         end_sim();
   endtask

   task automatic t_flags();
      logic [31:0] q;
      get(TPCU_OFS_CSC, q);
      chk("ch_flag", 32'h0000_0088, q);
      put(TPCU_OFS_IRQ_MASK, 8'h01);
      put(TPCU_OFS_IRQ_STAT, 8'h03);
      wait_irq();
      get(TPCU_OFS_TSC, q);
      chk("ovf_set", 32'h0000_00A8, q);
      put(TPCU_OFS_TSC, 8'h28);
      get(TPCU_OFS_TSC, q);
      chk("ovf_cleared", 32'h0000_0028, q);
      repeat (16) @(posedge sys_clk);
      put(TPCU_OFS_TSC, 8'h28);
      get(TPCU_OFS_TSC, q);
      chk("ovf_unarmed", 32'h0000_00A8, q);
      put(TPCU_OFS_IRQ_STAT, 8'h01);
      wait_irq();
      put(TPCU_OFS_IRQ_STAT, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk("irq_w1c", 32'h0000_0000, {31'h0, irq});
      put(TPCU_OFS_IRQ_MASK, 8'h00);
      repeat (20) @(posedge sys_clk);
      chk("irq_masked", 32'h0000_0000, {31'h0, irq});
      get(TPCU_OFS_IRQ_STAT, q);
      chk("stat_sticky", 32'h0000_0001, q & 32'h0000_0001);
   endtask

   task automatic t_halt();
      logic [31:0] q;
      logic [31:0] q2;
      put(TPCU_OFS_MOD_HI, 8'h00);
      debug_halt <= 1'b1;
      get(TPCU_OFS_CNT_LO, q);
      get(TPCU_OFS_CNT_LO, q2);
      chk("halt_freeze", q, q2);
      put(TPCU_OFS_CNT_LO, 8'h00);
      get(TPCU_OFS_CNT_LO, q);
      chk("cnt_cleared", 32'h0000_0000, q);
      put(TPCU_OFS_TSC, 8'h28);
      put(TPCU_OFS_MOD_LO, 8'h05);
      debug_halt <= 1'b0;
      repeat (2) @(posedge sys_clk);
      get(TPCU_OFS_MOD_LO, q);
      chk("mod_pair_drop", 32'h0000_0007, q);
      put(TPCU_OFS_MOD_HI, 8'h00);
      get(TPCU_OFS_MOD_LO, q);
      chk("mod_pair_new", 32'h0000_0005, q);
   endtask

   // =========================================================
   // Main sequence: reset for four cycles, then every scenario.
   initial
   begin
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      chk("irq_reset", 32'h0000_0000, {31'h0, irq});
      t_freeze();
      t_edge();
      t_center();
      t_flags();
      t_halt();
      end_sim();
   end
endmodule

/* File: tpcu_pair.sv */
// Purpose: Two-byte coherent write buffer for a 16-bit value.
// Assumes: Byte writes arrive as single-cycle strobes.
// Notes: Full stays set until taken; a new completion beats a take.
`timescale 1ns/100ps
module tpcu_pair
   import tpcu_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic wr_hi_i,
   input wire logic wr_lo_i,
   input wire logic [7:0] byte_i,
   input wire logic flush_i,
   input wire logic take_i,
   output logic [15:0] value_o,
   output logic full_o,
   output logic part_o
);
   logic hi_seen_r, hi_seen_nxt;
   logic lo_seen_r, lo_seen_nxt;
   logic [15:0] value_nxt;
   logic full_nxt;

   // =========================================================
   // Pairing: either byte may come first; the pair completes on the
   // second distinct byte.
   always_comb
   begin
      hi_seen_nxt = hi_seen_r | wr_hi_i;
      lo_seen_nxt = lo_seen_r | wr_lo_i;
      value_nxt = value_o;
      full_nxt = full_o & ~take_i;
      if (wr_hi_i)
         value_nxt[15:8] = byte_i;
      if (wr_lo_i)
         value_nxt[7:0] = byte_i;
      if (hi_seen_nxt && lo_seen_nxt)
      begin
         full_nxt = 1'b1; // R15
         hi_seen_nxt = 1'b0;
         lo_seen_nxt = 1'b0;
      end
      if (flush_i)
      begin
         hi_seen_nxt = 1'b0;
         lo_seen_nxt = 1'b0;
      end
   end

   // Registers only.
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hi_seen_r <= 1'b0;
         lo_seen_r <= 1'b0;
         value_o <= TPCU_VAL_RST;
         full_o <= 1'b0;
      end
      else
      begin
         hi_seen_r <= hi_seen_nxt;
         lo_seen_r <= lo_seen_nxt;
         value_o <= value_nxt;
         full_o <= full_nxt;
      end
   end

   assign part_o = hi_seen_r | lo_seen_r;

endmodule

/* File: tpcu_pkg.sv */
// Purpose: Constants for the 16-bit timer/PWM channel update block.
// Assumes: 32-bit Avalon-MM slave, one register per aligned word.
// Notes: Byte registers sit in data bits 7:0; upper bits read as zero.
//
// Behaviour
// R01: Edge PWM loads buffer at modulo-1 to modulo.
// R02: Center PWM loads buffer at modulo-1 to modulo.
// R03: Center PWM, value equals modulo: full duty.
// R04: Center PWM, value modulo-1: almost full duty.
// R05: Zero to nonzero waits for new period.
// R06: Nonzero to zero finishes current period first.
// R07: Control write in debug halt resets modulo pairing.
// R08: Clock select 00 freezes the PWM output.
// R09: Edge/level select 00 releases the channel pin.
// R10: Software starts via port, waits overflow, enables.
// R11: Center mode overflow at up-to-down turn.
// R12: Counter write clears counter and prescaler.
// R13: Flag clears by read-set then write-zero; event wins.
// R14: Center counts up then down; active below value.
// R15: Value buffered until both bytes are written.
package tpcu_pkg;

   // =========================================================
   // Register byte addresses
   localparam logic [5:0] TPCU_OFS_TSC = 6'h00;
   localparam logic [5:0] TPCU_OFS_CNT_HI = 6'h04;
   localparam logic [5:0] TPCU_OFS_CNT_LO = 6'h08;
   localparam logic [5:0] TPCU_OFS_MOD_HI = 6'h0C;
   localparam logic [5:0] TPCU_OFS_MOD_LO = 6'h10;
   localparam logic [5:0] TPCU_OFS_CSC = 6'h14;
   localparam logic [5:0] TPCU_OFS_VAL_HI = 6'h18;
   localparam logic [5:0] TPCU_OFS_VAL_LO = 6'h1C;
   localparam logic [5:0] TPCU_OFS_IRQ_STAT = 6'h20;
   localparam logic [5:0] TPCU_OFS_IRQ_MASK = 6'h24;

   // =========================================================
   // Field positions
   localparam int TPCU_FLAG_BIT = 7;
   localparam int TPCU_CPWM_BIT = 5;
   localparam int TPCU_CSEL_LSB = 3;
   localparam int TPCU_PS_LSB = 0;
   localparam int TPCU_ELS_LSB = 2;
   localparam int TPCU_IRQ_OVF = 0;
   localparam int TPCU_IRQ_CH = 1;

   // =========================================================
   // Reset values and fixed counts
   localparam logic [15:0] TPCU_CNT_RST = 16'h0000;
   localparam logic [15:0] TPCU_MOD_RST = 16'h0000;
   localparam logic [15:0] TPCU_VAL_RST = 16'h0000;
   localparam logic [15:0] TPCU_FREE_TOP = 16'hFFFF;
   localparam logic [1:0] TPCU_CSEL_OFF = 2'h0;
   localparam logic [1:0] TPCU_ELS_OFF = 2'h0;
   localparam logic [6:0] TPCU_PRE_RST = 7'h00;

   // Bus handshake states; bit 0 is the waitrequest level.
   typedef enum logic [1:0]
   {
      TPCU_BUS_WAIT = 2'b01,
      TPCU_BUS_ACK = 2'b10
   } tpcu_bus_e;

endpackage

/* File: tpcu_top.sv */
// Purpose: One PWM channel of a 16-bit timer with buffered duty value.
// Assumes: Single bus clock; debug halt comes from same-clock logic.
// Notes: Any clock select other than 00 counts on the bus clock.
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
module tpcu_top
   import tpcu_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic debug_halt_i,
   output logic chan_pin_o,
   output logic chan_pin_oe_o,
   output logic irq_o
);
   tpcu_bus_e bus_st_r, bus_st_nxt;
   logic [31:0] rdata_nxt;
   logic req, acc_wr, acc_rd;
   logic [7:0] wbyte;
   logic [1:0] csel_r, csel_nxt, els_r, els_nxt;
   logic cpwm_r, cpwm_nxt;
   logic [2:0] ps_r, ps_nxt;
   logic [15:0] cnt_r, cnt_nxt, mod_r, mod_nxt, val_r, val_nxt, top;
   logic [6:0] pre_r, pre_nxt, pre_lim;
   logic up_r, up_nxt, pwm_r, pwm_nxt;
   logic pin_nxt, oe_nxt, irq_nxt;
   logic ovf_f_r, ovf_f_nxt, ch_f_r, ch_f_nxt;
   logic ovf_arm_r, ovf_arm_nxt, ch_arm_r, ch_arm_nxt;
   logic [1:0] ist_r, ist_nxt, imask_r, imask_nxt;
   logic tick, ovf_evt, ch_evt, load, cnt_wr, tsc_wr, csc_wr;
   logic val_hi_wr, val_lo_wr, mod_hi_wr, mod_lo_wr;
   logic [15:0] val_buf, mod_buf;
   logic val_full, mod_full, mod_part, val_part;

   // =========================================================
   // Avalon slave: one wait cycle, then the access is accepted.
   assign req = avs_read_i | avs_write_i;
   assign acc_wr = avs_write_i & (bus_st_r == TPCU_BUS_ACK);
   assign acc_rd = avs_read_i & (bus_st_r == TPCU_BUS_ACK);
   assign wbyte = avs_writedata_i[7:0];
   assign cnt_wr = acc_wr & ((avs_address_i == TPCU_OFS_CNT_HI) |
                             (avs_address_i == TPCU_OFS_CNT_LO));
   assign tsc_wr = acc_wr & (avs_address_i == TPCU_OFS_TSC);
   assign csc_wr = acc_wr & (avs_address_i == TPCU_OFS_CSC);
   assign val_hi_wr = acc_wr & (avs_address_i == TPCU_OFS_VAL_HI);
   assign val_lo_wr = acc_wr & (avs_address_i == TPCU_OFS_VAL_LO);
   assign mod_hi_wr = acc_wr & (avs_address_i == TPCU_OFS_MOD_HI);
   assign mod_lo_wr = acc_wr & (avs_address_i == TPCU_OFS_MOD_LO);

   // Read data is prepared in the wait cycle so it is a flop output.
   always_comb
   begin
      bus_st_nxt = TPCU_BUS_WAIT;
      rdata_nxt = avs_readdata_o;
      unique case (bus_st_r)
         TPCU_BUS_WAIT:
         begin
            if (req)
               bus_st_nxt = TPCU_BUS_ACK;
            rdata_nxt = 32'h0000_0000;
            unique case (avs_address_i)
               TPCU_OFS_TSC: rdata_nxt[7:0] = {ovf_f_r, 1'b0, cpwm_r,
                                                csel_r, ps_r};
               TPCU_OFS_CNT_HI: rdata_nxt[7:0] = cnt_r[15:8];
               TPCU_OFS_CNT_LO: rdata_nxt[7:0] = cnt_r[7:0];
               TPCU_OFS_MOD_HI: rdata_nxt[7:0] = mod_r[15:8];
               TPCU_OFS_MOD_LO: rdata_nxt[7:0] = mod_r[7:0];
               TPCU_OFS_CSC: rdata_nxt[7:0] = {ch_f_r, 3'h0, els_r, 2'h0};
               TPCU_OFS_VAL_HI: rdata_nxt[7:0] = val_r[15:8];
               TPCU_OFS_VAL_LO: rdata_nxt[7:0] = val_r[7:0];
               TPCU_OFS_IRQ_STAT: rdata_nxt[1:0] = ist_r;
               TPCU_OFS_IRQ_MASK: rdata_nxt[1:0] = imask_r;
               default: rdata_nxt = 32'h0000_0000;
            endcase
         end
         TPCU_BUS_ACK: bus_st_nxt = TPCU_BUS_WAIT;
         default: bus_st_nxt = TPCU_BUS_WAIT;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         bus_st_r <= TPCU_BUS_WAIT;
         avs_readdata_o <= 32'h0000_0000;
      end
      else
      begin
         bus_st_r <= bus_st_nxt;
         avs_readdata_o <= rdata_nxt;
      end
   end

   assign avs_waitrequest_o = bus_st_r[0];

   // =========================================================
   // Byte-pair buffers. The modulo pair is flushed by a control write
   // in debug halt so a half-written modulo cannot complete later.
   tpcu_pair u_val
   (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .wr_hi_i(val_hi_wr),
      .wr_lo_i(val_lo_wr),
      .byte_i(wbyte),
      .flush_i(1'b0),
      .take_i(load),
      .value_o(val_buf),
      .full_o(val_full),
      .part_o(val_part)
   );

   tpcu_pair u_mod
   (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .wr_hi_i(mod_hi_wr),
      .wr_lo_i(mod_lo_wr),
      .byte_i(wbyte),
      .flush_i(tsc_wr & debug_halt_i), // R07
      .take_i(mod_full),
      .value_o(mod_buf),
      .full_o(mod_full),
      .part_o(mod_part)
   );

   // =========================================================
   // Counter, prescaler and buffered duty load.
   assign top = (mod_r == TPCU_MOD_RST) ? TPCU_FREE_TOP : mod_r;
   assign pre_lim = 7'((8'h01 << ps_r) - 8'h01);
   assign tick = (csel_r != TPCU_CSEL_OFF) & ~debug_halt_i &
                 (pre_r >= pre_lim); // R08
   // Loading one step before the top makes it land on the period edge.
   assign load = tick & val_full & (~cpwm_r | up_r) &
                 (cnt_r == 16'(top - 16'h0001)); // R01 R02 R05 R06

   always_comb
   begin
      cnt_nxt = cnt_r;
      pre_nxt = pre_r;
      up_nxt = up_r;
      val_nxt = load ? val_buf : val_r;
      mod_nxt = mod_full ? mod_buf : mod_r;
      pwm_nxt = pwm_r;
      ovf_evt = 1'b0;
      ch_evt = tick & (cnt_r == val_r);
      if ((csel_r != TPCU_CSEL_OFF) && !debug_halt_i)
         pre_nxt = tick ? TPCU_PRE_RST : 7'(pre_r + 7'h01);
      if (tick)
      begin
         if (!cpwm_r)
         begin
            ovf_evt = (cnt_r == top);
            cnt_nxt = ovf_evt ? TPCU_CNT_RST : 16'(cnt_r + 16'h0001);
         end
         else if (up_r)
         begin
            if (cnt_r >= top)
            begin
               ovf_evt = 1'b1; // R11
               up_nxt = 1'b0;
               cnt_nxt = 16'(cnt_r - 16'h0001);
            end
            else
               cnt_nxt = 16'(cnt_r + 16'h0001); // R14
         end
         else if (cnt_r == TPCU_CNT_RST)
         begin
            up_nxt = 1'b1;
            cnt_nxt = 16'(cnt_r + 16'h0001);
         end
         else
            cnt_nxt = 16'(cnt_r - 16'h0001); // R14
         // In center mode, value at modulo gives full duty, modulo-1 almost full.
         pwm_nxt = (cnt_nxt < val_nxt) |
                   (cpwm_r & (val_nxt == top)); // R03 R04 R14
      end
      if (cnt_wr)
      begin
         cnt_nxt = TPCU_CNT_RST; // R12
         pre_nxt = TPCU_PRE_RST; // R12
         up_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt_r <= TPCU_CNT_RST;
         pre_r <= TPCU_PRE_RST;
         up_r <= 1'b1;
         val_r <= TPCU_VAL_RST;
         mod_r <= TPCU_MOD_RST;
         pwm_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         pre_r <= pre_nxt;
         up_r <= up_nxt;
         val_r <= val_nxt;
         mod_r <= mod_nxt;
         pwm_r <= pwm_nxt;
      end
   end

   // =========================================================
   // Control, flags and interrupt. A new event beats any clear.
   always_comb
   begin
      csel_nxt = csel_r;
      cpwm_nxt = cpwm_r;
      ps_nxt = ps_r;
      els_nxt = els_r;
      imask_nxt = imask_r;
      ovf_f_nxt = ovf_f_r;
      ovf_arm_nxt = ovf_arm_r;
      ch_f_nxt = ch_f_r;
      ch_arm_nxt = ch_arm_r;
      ist_nxt = ist_r;
      if (acc_rd && (avs_address_i == TPCU_OFS_TSC) && ovf_f_r)
         ovf_arm_nxt = 1'b1;
      if (acc_rd && (avs_address_i == TPCU_OFS_CSC) && ch_f_r)
         ch_arm_nxt = 1'b1;
      if (tsc_wr)
      begin
         csel_nxt = wbyte[TPCU_CSEL_LSB +: 2];
         cpwm_nxt = wbyte[TPCU_CPWM_BIT];
         ps_nxt = wbyte[TPCU_PS_LSB +: 3];
         if (ovf_arm_r && !wbyte[TPCU_FLAG_BIT])
            ovf_f_nxt = 1'b0; // R13
         ovf_arm_nxt = 1'b0;
      end
      if (csc_wr)
      begin
         els_nxt = wbyte[TPCU_ELS_LSB +: 2];
         if (ch_arm_r && !wbyte[TPCU_FLAG_BIT])
            ch_f_nxt = 1'b0; // R13
         ch_arm_nxt = 1'b0;
      end
      if (acc_wr && (avs_address_i == TPCU_OFS_IRQ_MASK))
         imask_nxt = wbyte[1:0];
      if (acc_wr && (avs_address_i == TPCU_OFS_IRQ_STAT))
         ist_nxt = ist_r & ~wbyte[1:0];
      if (ovf_evt)
      begin
         ovf_f_nxt = 1'b1; // R13
         ovf_arm_nxt = 1'b0;
         ist_nxt[TPCU_IRQ_OVF] = 1'b1;
      end
      if (ch_evt)
      begin
         ch_f_nxt = 1'b1; // R13
         ch_arm_nxt = 1'b0;
         ist_nxt[TPCU_IRQ_CH] = 1'b1;
      end
      irq_nxt = |(ist_nxt & imask_nxt);
      // Pin follows the frozen waveform; 00 leaves it to the port.
      oe_nxt = (els_r != TPCU_ELS_OFF); // R09
      pin_nxt = pwm_r ^ els_r[0];
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         csel_r <= TPCU_CSEL_OFF;
         cpwm_r <= 1'b0;
         ps_r <= 3'h0;
         els_r <= TPCU_ELS_OFF;
         imask_r <= 2'h0;
         ovf_f_r <= 1'b0;
         ovf_arm_r <= 1'b0;
         ch_f_r <= 1'b0;
         ch_arm_r <= 1'b0;
         ist_r <= 2'h0;
         irq_o <= 1'b0;
         chan_pin_oe_o <= 1'b0;
         chan_pin_o <= 1'b0;
      end
      else
      begin
         csel_r <= csel_nxt;
         cpwm_r <= cpwm_nxt;
         ps_r <= ps_nxt;
         els_r <= els_nxt;
         imask_r <= imask_nxt;
         ovf_f_r <= ovf_f_nxt;
         ovf_arm_r <= ovf_arm_nxt;
         ch_f_r <= ch_f_nxt;
         ch_arm_r <= ch_arm_nxt;
         ist_r <= ist_nxt;
         irq_o <= irq_nxt;
         chan_pin_oe_o <= oe_nxt;
         chan_pin_o <= pin_nxt;
      end
   end

   // =========================================================
   // Checks.
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   pwm_frozen_a: assert property ((csel_r == TPCU_CSEL_OFF) |=> // R08
      $stable(pwm_r)) else $error("PWM changed with clock off");
   edge_wrap_a: assert property (tick && !cpwm_r && !cnt_wr && // R01
      (cnt_r == top) |=> (cnt_r == 16'h0000) && ovf_f_r)
      else $error("Edge counter did not wrap at top");
   center_turn_a: assert property (tick && cpwm_r && up_r && // R11
      !cnt_wr && (cnt_r == top) |=> !up_r && ovf_f_r)
      else $error("Center turn missed overflow");
   load_point_a: assert property ((val_r != $past(val_r)) |-> // R02
      $past(load)) else $error("Duty value loaded off the load point");
   full_duty_a: assert property (tick && cpwm_r && // R03
      (val_nxt == top) |=> pwm_r) else $error("Full duty not held");
   pin_release_a: assert property ((els_r == TPCU_ELS_OFF) |=> // R09
      !chan_pin_oe_o) else $error("Pin driven with select 00");
   cnt_clear_a: assert property (cnt_wr |=> // R12
      (cnt_r == 16'h0000) && (pre_r == 7'h00))
      else $error("Counter write did not clear");
   flag_wins_a: assert property (ovf_evt |=> ovf_f_r ##1 // R13
      (ovf_f_r || $past(tsc_wr))) else $error("Overflow event lost");
   mod_flush_a: assert property (tsc_wr && debug_halt_i |=> // R07
      !mod_part) else $error("Modulo pairing not reset in halt");
   pair_need_a: assert property (val_hi_wr && !val_full && // R15
      !val_part ##1 !val_lo_wr [*2] |-> !val_full || $past(val_lo_wr, 2))
      else $error("Duty buffer completed on one byte");
   bus_wait_a: assert property (req && avs_waitrequest_o |=>
      !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("Bus answer not after one wait cycle");

   load_cov_c: cover property (load ##1 tick);
   center_cov_c: cover property (tick && cpwm_r && up_r && (cnt_r == top));
   irq_cov_c: cover property (!irq_o ##1 irq_o);

endmodule
